// File: bsfc_pkg.sv
package bsfc_pkg;
	// ************************************************************
	// register map (byte addresses, one aligned word each)
	// ************************************************************
	localparam logic [7:0] BSFC_IDX_LIMITS = 8'h0a;
	localparam logic [11:0] BSFC_ADDR_LIMITS = 12'h028;
	localparam logic [11:0] BSFC_ADDR_CTRL = 12'h000;
	localparam logic [11:0] BSFC_ADDR_STATUS = 12'h004;
	localparam logic [11:0] BSFC_ADDR_MASK = 12'h008;
	localparam logic [11:0] BSFC_ADDR_RESULT = 12'h00c;
	localparam logic [11:0] BSFC_ADDR_FAULT = 12'h010;

	// ************************************************************
	// fields and reset values
	// ************************************************************
	localparam int BSFC_LOW_LSB = 0;
	localparam int BSFC_HIGH_LSB = 8;
	localparam int BSFC_CTRL_NOM = 0;
	localparam int BSFC_CTRL_CHK = 1;
	localparam int BSFC_CTRL_REINIT = 2;
	localparam int BSFC_RES_LSB = 4;
	localparam int BSFC_ST_CM = 0;
	localparam int BSFC_ST_WB = 1;
	localparam int BSFC_ST_SHORT = 2;
	localparam int BSFC_ST_DONE = 3;
	localparam logic [15:0] BSFC_LIMITS_RST = 16'hff00;
	localparam logic [3:0] BSFC_MASK_RST = 4'h0;
	localparam logic [4:0] BSFC_RES_MIN = 5'h0d;
	localparam logic [4:0] BSFC_RES_MAX = 5'h10;
	localparam int BSFC_INT_BITS = 13;
	localparam int BSFC_LIM_SHIFT = 5;

	typedef enum logic [2:0] {
		BSFC_IDLE, BSFC_CM, BSFC_POS, BSFC_NEG, BSFC_EVAL
	} bsfc_task_t;
endpackage

// File: bsfc_scaler.sv
module bsfc_scaler
	import bsfc_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic load,
	input wire logic [15:0] raw,
	input wire logic [1:0] res_sel,
	output logic [12:0] scaled
);
	// registered divide by 2^(res-13): shift right by the resolution excess
	logic [12:0] next_scaled;

	always_comb begin
		next_scaled = scaled;
		if (load) begin
			next_scaled = 13'(raw >> res_sel);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			scaled <= 13'h0000;
		end else begin
			scaled <= next_scaled;
		end
	end
endmodule

// File: bsfc_top.sv
// Operation
// - nom repeatedly measures and compares common mode
// - limit word: low [7:0], high [15:8]
// - error when outside limits, none within
// - scale result to 13 bits by shift
// - one enable drives both sensor checks
// - wire break comparators watch four wires
// - short check adds positive, negative tasks
// - short declared when forced difference too small
// - repeat reversed polarity to cancel offset
//
// The AHB-Lite register port is this design's own decision.
module bsfc_top
	import bsfc_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic cycle_start,
	input wire logic conv_valid,
	input wire logic [15:0] conv_result,
	input wire logic [3:0] wire_cmp_open,
	input wire logic [15:0] short_threshold,
	output logic common_mode_conversion_command,
	output logic bias_pos,
	output logic bias_neg,
	output logic sensor_fault,
	output logic irq
);
	// ************************************************************
	// bus slave
	// ************************************************************
	logic wr_pend, next_wr_pend;
	logic [11:0] wr_addr, next_wr_addr;
	logic [31:0] next_hrdata;
	logic [15:0] limits, next_limits;
	logic normal_operation_mode, next_nom;
	logic sensor_check_enable, next_chk;
	logic [2:0] adc_resolution_bits, next_res;
	logic [3:0] status, next_status;
	logic [3:0] mask, next_mask;
	logic fault, next_fault;
	logic irq_q, next_irq;
	logic [3:0] ev;
	logic reinit;
	logic [12:0] zero_corrected_common_mode_result;
	logic addr_ph;

	assign addr_ph = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign irq = irq_q;
	assign sensor_fault = fault;
	assign reinit = wr_pend && wr_addr == BSFC_ADDR_CTRL && hwdata[BSFC_CTRL_REINIT];

	always_comb begin
		next_wr_pend = addr_ph && hwrite;
		next_wr_addr = addr_ph ? haddr[11:0] : wr_addr;
		next_hrdata = hrdata;
		next_limits = limits;
		next_nom = normal_operation_mode;
		next_chk = sensor_check_enable;
		next_res = adc_resolution_bits;
		next_mask = mask;
		next_status = status;
		if (wr_pend) begin
			unique case (wr_addr)
				BSFC_ADDR_LIMITS: next_limits = hwdata[15:0];
				BSFC_ADDR_CTRL: begin
					next_nom = hwdata[BSFC_CTRL_NOM];
					next_chk = hwdata[BSFC_CTRL_CHK];
					next_res = hwdata[BSFC_RES_LSB +: 3];
				end
				BSFC_ADDR_MASK: next_mask = hwdata[3:0];
				BSFC_ADDR_STATUS: next_status = status & ~hwdata[3:0];
				default: ;
			endcase
		end
		next_status = next_status | ev; // set beats clear
		if (addr_ph && !hwrite) begin
			unique case (haddr[11:0])
				BSFC_ADDR_LIMITS: next_hrdata = {16'h0000, limits};
				BSFC_ADDR_CTRL: next_hrdata = {25'h0, adc_resolution_bits, 1'b0,
					1'b0, sensor_check_enable, normal_operation_mode};
				BSFC_ADDR_STATUS: next_hrdata = {28'h0, status};
				BSFC_ADDR_MASK: next_hrdata = {28'h0, mask};
				BSFC_ADDR_RESULT: next_hrdata = {19'h0, zero_corrected_common_mode_result};
				BSFC_ADDR_FAULT: next_hrdata = {31'h0, fault};
				default: next_hrdata = 32'h0000_0000;
			endcase
		end
		// next_mask as well, so irq follows a mask write in the same cycle
		next_irq = |(next_status & next_mask);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 12'h000;
			hrdata <= 32'h0000_0000;
			limits <= BSFC_LIMITS_RST;
			normal_operation_mode <= 1'b0;
			sensor_check_enable <= 1'b0;
			adc_resolution_bits <= 3'h0;
			mask <= BSFC_MASK_RST;
			status <= 4'h0;
			irq_q <= 1'b0;
		end else begin
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			hrdata <= next_hrdata;
			limits <= next_limits;
			normal_operation_mode <= next_nom;
			sensor_check_enable <= next_chk;
			adc_resolution_bits <= next_res;
			mask <= next_mask;
			status <= next_status;
			irq_q <= next_irq;
		end
	end

	// ************************************************************
	// measurement task sequence
	// ************************************************************
	bsfc_task_t task_q, next_task;
	logic cmd_q, next_cmd;
	logic bp_q, next_bp;
	logic bn_q, next_bn;
	logic cm_load;
	logic signed [16:0] diff_pos, next_diff_pos;
	logic signed [16:0] diff_neg, next_diff_neg;
	logic [1:0] res_sel;
	logic [13:0] lo_lim, hi_lim;
	logic cm_err, wb_err, short_err;
	logic [16:0] swing;

	// resolution field holds 13..16 as 0..3 excess; larger codes clamp at 16
	assign res_sel = adc_resolution_bits > 3'h3 ? 2'h3 : adc_resolution_bits[1:0];
	assign common_mode_conversion_command = cmd_q;
	assign bias_pos = bp_q;
	assign bias_neg = bn_q;
	assign cm_load = task_q == BSFC_CM && conv_valid;

	bsfc_scaler u_scaler (
		.hclk(hclk),
		.hresetn(hresetn),
		.load(cm_load),
		.raw(conv_result),
		.res_sel(res_sel),
		.scaled(zero_corrected_common_mode_result)
	);

	// limits are 8-bit codes of the 13-bit domain, one step is 32 counts
	assign lo_lim = {1'b0, limits[BSFC_LOW_LSB +: 8], 5'h00};
	assign hi_lim = {1'b0, limits[BSFC_HIGH_LSB +: 8], 5'h00};
	// difference of both polarities cancels bridge offset: swing = pos - neg
	assign swing = 17'(diff_pos - diff_neg);

	always_comb begin
		next_task = task_q;
		next_cmd = 1'b0;
		next_bp = bp_q;
		next_bn = bn_q;
		next_diff_pos = diff_pos;
		next_diff_neg = diff_neg;
		unique case (task_q)
			BSFC_IDLE: if (normal_operation_mode && cycle_start) begin
				next_task = BSFC_CM;
				next_cmd = 1'b1;
			end
			BSFC_CM: if (conv_valid) begin
				if (sensor_check_enable) begin
					next_task = BSFC_POS;
					next_bp = 1'b1;
				end else begin
					next_task = BSFC_EVAL;
				end
			end
			BSFC_POS: if (conv_valid) begin
				next_diff_pos = 17'(signed'(conv_result));
				next_task = BSFC_NEG;
				next_bp = 1'b0;
				next_bn = 1'b1;
			end
			BSFC_NEG: if (conv_valid) begin
				next_diff_neg = 17'(signed'(conv_result));
				next_task = BSFC_EVAL;
				next_bn = 1'b0;
			end
			BSFC_EVAL: next_task = BSFC_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			task_q <= BSFC_IDLE;
			cmd_q <= 1'b0;
			bp_q <= 1'b0;
			bn_q <= 1'b0;
			diff_pos <= 17'h00000;
			diff_neg <= 17'h00000;
		end else begin
			task_q <= next_task;
			cmd_q <= next_cmd;
			bp_q <= next_bp;
			bn_q <= next_bn;
			diff_pos <= next_diff_pos;
			diff_neg <= next_diff_neg;
		end
	end

	// ************************************************************
	// fault evaluation
	// ************************************************************
	always_comb begin
		cm_err = {1'b0, zero_corrected_common_mode_result} < lo_lim
			|| {1'b0, zero_corrected_common_mode_result} > hi_lim;
		wb_err = sensor_check_enable && |wire_cmp_open;
		short_err = sensor_check_enable && swing[16] == 1'b0
			&& swing[15:0] < short_threshold;
		if (swing[16]) begin
			short_err = sensor_check_enable; // reversed sign is implausible
		end
		ev = 4'h0;
		if (task_q == BSFC_EVAL) begin
			ev[BSFC_ST_CM] = cm_err;
			ev[BSFC_ST_SHORT] = short_err && sensor_check_enable;
			ev[BSFC_ST_DONE] = 1'b1;
		end
		// comparators are watched every cycle, so a break between cycles still flags
		ev[BSFC_ST_WB] = wb_err;
		next_fault = reinit ? 1'b0 : fault;
		if (|ev[2:0]) begin
			next_fault = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fault <= 1'b0;
		end else begin
			fault <= next_fault;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	sequence s_short_tasks;
		task_q == BSFC_POS && bias_pos ##[1:1000] task_q == BSFC_NEG && bias_neg;
	endsequence

	a_fault_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
		fault && !reinit |=> fault) else $error("fault flag dropped");
	a_cm_flag: assert property (@(posedge hclk) disable iff (!hresetn)
		task_q == BSFC_EVAL && cm_err |=> status[BSFC_ST_CM] && fault)
		else $error("common mode error not flagged");
	a_check_tasks: assert property (@(posedge hclk) disable iff (!hresetn)
		task_q == BSFC_CM && conv_valid && sensor_check_enable |=> s_short_tasks)
		else $error("short tasks not inserted");
	a_no_check_off: assert property (@(posedge hclk) disable iff (!hresetn)
		task_q == BSFC_CM && conv_valid && !sensor_check_enable |=> task_q == BSFC_EVAL)
		else $error("short task ran while disabled");
	a_cycle_start: assert property (@(posedge hclk) disable iff (!hresetn)
		task_q == BSFC_IDLE && normal_operation_mode && cycle_start
		|=> common_mode_conversion_command ##1 !common_mode_conversion_command)
		else $error("no common mode conversion");
	a_wire_break: assert property (@(posedge hclk) disable iff (!hresetn)
		sensor_check_enable && |wire_cmp_open |=> status[BSFC_ST_WB])
		else $error("wire break missed");
	a_scale: assert property (@(posedge hclk) disable iff (!hresetn)
		cm_load |=> zero_corrected_common_mode_result == 13'($past(conv_result) >> $past(res_sel)))
		else $error("scaling wrong");
	a_limit_map: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_pend && wr_addr == BSFC_ADDR_LIMITS |=> lo_lim[12:5] == $past(hwdata[7:0])
		&& hi_lim[12:5] == $past(hwdata[15:8])) else $error("limit fields misplaced");
	a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
		|(status & mask) |-> irq) else $error("irq not raised");
	a_short_flag: assert property (@(posedge hclk) disable iff (!hresetn)
		task_q == BSFC_EVAL && short_err |=> status[BSFC_ST_SHORT] && fault)
		else $error("short not flagged");
	a_bias_excl: assert property (@(posedge hclk) disable iff (!hresetn)
		!(bias_pos && bias_neg)) else $error("both bias polarities on");
	a_reinit_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		reinit && !(|ev[2:0]) |=> !fault)
		else $error("reinit did not clear fault");
	a_cm_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
		task_q == BSFC_EVAL && !cm_err |=> !$rose(status[BSFC_ST_CM]))
		else $error("common mode error inside limits");
	a_cmd_task: assert property (@(posedge hclk) disable iff (!hresetn)
		common_mode_conversion_command |-> task_q == BSFC_CM) else $error("stray command");
	a_nom_off: assert property (@(posedge hclk) disable iff (!hresetn)
		task_q == BSFC_IDLE && !normal_operation_mode |=> task_q == BSFC_IDLE)
		else $error("cycle started outside normal mode");
endmodule

// File: bsfc_bridge_model.sv
module bsfc_bridge_model (
	input wire logic hclk,
	input wire logic common_mode_conversion_command,
	input wire logic bias_pos,
	input wire logic bias_neg,
	input wire logic [15:0] cm_val,
	input wire logic [15:0] pos_val,
	input wire logic [15:0] neg_val,
	input wire logic [3:0] wire_open,
	input wire logic [3:0] lag,
	output logic conv_valid,
	output logic [15:0] conv_result,
	output logic [3:0] wire_cmp_open
);
	timeunit 1ns;
	timeprecision 1ps;
	// ************************************************************
	// bridge front end: one conversion per request
	// ************************************************************
	assign wire_cmp_open = wire_open;
	task automatic answer(input logic [15:0] v);
		repeat (lag) @(posedge hclk);
		conv_valid <= 1'b1;
		conv_result <= v;
		@(posedge hclk);
		conv_valid <= 1'b0;
		// released result shows the inverse so a stale read cannot pass
		conv_result <= ~v;
	endtask
	initial begin
		conv_valid = 1'b0;
		conv_result = 16'h0;
		forever begin
			@(posedge hclk);
			#1;
			if (common_mode_conversion_command) answer(cm_val);
			else if (bias_pos) answer(pos_val);
			else if (bias_neg) answer(neg_val);
		end
	end
endmodule

// File: tb_bsfc_top.sv
module tb_bsfc_top
	import bsfc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk, hresetn, hsel, hwrite, cycle_start, conv_valid, hreadyout, cmd;
	logic bias_pos, bias_neg, sensor_fault, irq, hresp;
	logic [1:0] htrans;
	logic [1:0] seen = 2'h0;
	logic [3:0] wire_open, wire_cmp_open, lag;
	logic [31:0] haddr, hwdata, hrdata;
	logic [15:0] cm_val, pos_val, neg_val, conv_result;
	int err_total = 0;
	int cmp_count = 0;
	int cycles = 0;

	bsfc_top bsfc_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cycle_start(cycle_start),
		.conv_valid(conv_valid), .conv_result(conv_result), .wire_cmp_open(wire_cmp_open),
		.short_threshold(16'h0200), .common_mode_conversion_command(cmd),
		.bias_pos(bias_pos), .bias_neg(bias_neg), .sensor_fault(sensor_fault), .irq(irq));
	bsfc_bridge_model bsfc_bridge_model_inst (.hclk(hclk),
		.common_mode_conversion_command(cmd), .bias_pos(bias_pos), .bias_neg(bias_neg),
		.cm_val(cm_val), .pos_val(pos_val), .neg_val(neg_val), .wire_open(wire_open),
		.lag(lag), .conv_valid(conv_valid), .conv_result(conv_result),
		.wire_cmp_open(wire_cmp_open));

	// ************************************************************
	// clock, timeout and bus tasks
	// ************************************************************
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		seen <= cycle_start ? 2'h0 : seen | {bias_neg, bias_pos};
		cycles++;
		if (cycles == 30000) begin
			err_total++;
			tally_and_finish;
		end
	end
	task automatic tally_and_finish;
		if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] want);
		cmp_count++;
		if (got !== want) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
		end
	endtask
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	// one full measurement cycle, then status, result and clear
	task automatic run(input logic [15:0] cm, input logic [15:0] p, input logic [15:0] n,
		input logic [3:0] wo, input logic [2:0] res, input logic chk, input logic [3:0] st);
		logic [31:0] d;
		cm_val <= cm;
		pos_val <= p;
		neg_val <= n;
		xfer(1'b1, BSFC_ADDR_CTRL, {25'h0, res, 2'h0, chk, 1'b1}, d);
		// wires open only once the new enable stands, the old one must not see them
		wire_open <= wo;
		cycle_start <= 1'b1;
		@(posedge hclk);
		cycle_start <= 1'b0;
		d = 32'h0;
		for (int i = 0; i < 60 && !d[BSFC_ST_DONE]; i++) xfer(1'b0, BSFC_ADDR_STATUS, 32'h0, d);
		check(d, {28'h0, st});
		check(irq, st[BSFC_ST_CM]);
		check(seen, {chk, chk});
		xfer(1'b0, BSFC_ADDR_RESULT, 32'h0, d);
		check(d, {16'h0, cm >> res});
		wire_open <= 4'h0;
		xfer(1'b1, BSFC_ADDR_STATUS, 32'hf, d);
		repeat (2) @(posedge hclk);
		check(irq, 1'b0);
	endtask

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		logic [31:0] d;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		cycle_start = 1'b0;
		cm_val = 16'h0;
		pos_val = 16'h0;
		neg_val = 16'h0;
		wire_open = 4'h0;
		lag = 4'h0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		xfer(1'b0, BSFC_ADDR_LIMITS, 32'h0, d);
		check(d, 32'h0000ff00);
		check(hresp, 1'b0);
		xfer(1'b0, 12'h3fc, 32'h0, d);
		check(d, 32'h0);
		xfer(1'b1, BSFC_ADDR_LIMITS, 32'h8040, d);
		xfer(1'b0, BSFC_ADDR_LIMITS, 32'h0, d);
		check(d, 32'h8040);
		xfer(1'b1, BSFC_ADDR_MASK, 32'h1, d);
		run(16'h0800, 16'h0, 16'h0, 4'h0, 3'h0, 1'b0, 4'h8);
		run(16'h07ff, 16'h0, 16'h0, 4'h0, 3'h0, 1'b0, 4'h9);
		run(16'h1000, 16'h0, 16'h0, 4'h0, 3'h0, 1'b0, 4'h8);
		run(16'h1001, 16'h0, 16'h0, 4'h0, 3'h0, 1'b0, 4'h9);
		run(16'h8000, 16'h0, 16'h0, 4'h0, 3'h3, 1'b0, 4'h8);
		run(16'h8008, 16'h0, 16'h0, 4'h0, 3'h3, 1'b0, 4'h9);
		check(sensor_fault, 1'b1);
		xfer(1'b0, BSFC_ADDR_FAULT, 32'h0, d);
		check(d, 32'h1);
		xfer(1'b1, BSFC_ADDR_CTRL, 32'h4, d);
		xfer(1'b0, BSFC_ADDR_FAULT, 32'h0, d);
		check(d, 32'h0);
		lag <= 4'h3;
		run(16'h0c00, 16'h0400, 16'hfc00, 4'h0, 3'h0, 1'b1, 4'h8);
		run(16'h0c00, 16'h3000, 16'h2f00, 4'h0, 3'h0, 1'b1, 4'hc);
		run(16'h0c00, 16'hfc00, 16'h0400, 4'h0, 3'h0, 1'b1, 4'hc);
		run(16'h0c00, 16'h0400, 16'hfc00, 4'h4, 3'h0, 1'b1, 4'ha);
		run(16'h0c00, 16'h0400, 16'hfc00, 4'h4, 3'h0, 1'b0, 4'h8);
		check(sensor_fault, 1'b1);
		xfer(1'b1, BSFC_ADDR_CTRL, 32'h0, d);
		cycle_start <= 1'b1;
		@(posedge hclk);
		cycle_start <= 1'b0;
		repeat (10) @(posedge hclk);
		xfer(1'b0, BSFC_ADDR_STATUS, 32'h0, d);
		check(d, 32'h0);
		tally_and_finish;
	end
endmodule
